// >>> include/tcs_pkg.sv
package tcs_pkg;
  // Clock and time base
  localparam int CLK_HZ         = 50_000_000;
  localparam int MS_PER_S       = 1000;
  localparam int MS_TICK_CYCLES = CLK_HZ / MS_PER_S;
  localparam int S_PER_MIN      = 60;
  localparam int S_PER_H        = 3600;
  // Deglitch and indication times in ms, blink rate in Hz
  localparam int TERM_DGL_MS    = 200;
  localparam int RECHG_DGL_MS   = 200;
  localparam int HOLDOFF_MS     = 200;
  localparam int BLINK_HZ       = 1;
  localparam int BLINK_HALF_MS  = MS_PER_S / (2 * BLINK_HZ);
  // Safety timers
  localparam int PRE_TIMER_MIN  = 60;
  localparam int PRE_TIMER_S    = PRE_TIMER_MIN * S_PER_MIN;
  localparam int SAFE_H_1       = 5;
  localparam int SAFE_H_2       = 10;
  localparam int SAFE_H_3       = 20;
  localparam int TIMER_W        = 18;
  localparam logic [1:0] TMR_OFF = 2'h0;
  // Watchdog durations in seconds
  localparam int WDT_S_1        = 40;
  localparam int WDT_S_2        = 80;
  localparam int WDT_S_3        = 160;
  localparam int WDT_W          = 8;
  localparam logic [1:0] WDT_OFF = 2'h0;
  // Regulation voltage in mV, standalone bands
  localparam logic [13:0] VREG_BAND0_MV = 14'h20d0;
  localparam logic [13:0] VREG_BAND1_MV = 14'h2198;
  localparam logic [13:0] VREG_BAND2_MV = 14'h21fc;
  localparam logic [13:0] VREG_BAND3_MV = 14'h2260;
  localparam logic [3:0]  CURRENT_FULL_SCALE = 4'hf;
  // Charge sequence states
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_PRE   = 5'h02,
    ST_FAST  = 5'h04,
    ST_FULL  = 5'h08,
    ST_FAULT = 5'h10
  } tcs_state_type;
endpackage

// >>> verilog/tcs_tick_gen.sv
`timescale 1ns/1ps
// Millisecond, second and 1Hz blink time base
module tcs_tick_gen #(
  parameter int PRESCALE = tcs_pkg::MS_TICK_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst,
  output logic      ms_tick,
  output logic      s_tick,
  output logic      blink
);
  localparam int PW = $clog2(PRESCALE);
  localparam logic [PW-1:0] PRE_LAST = PW'(PRESCALE - 1);
  localparam logic [9:0] MS_LAST = 10'(tcs_pkg::MS_PER_S - 1);
  localparam logic [9:0] HALF_LAST = 10'(tcs_pkg::BLINK_HALF_MS - 1);

  logic [PW-1:0] pre_cnt;
  logic [9:0]    ms_cnt;
  logic [PW-1:0] next_pre_cnt;
  logic [9:0]    next_ms_cnt;
  logic          next_ms_tick;
  logic          next_s_tick;
  logic          next_blink;

  // Count cycles into ms, ms into seconds, toggle blink each half second
  always_comb begin
    next_ms_tick = (pre_cnt == PRE_LAST);
    next_pre_cnt = next_ms_tick ? '0 : pre_cnt + 1'b1;
    next_ms_cnt  = ms_cnt;
    next_s_tick  = 1'b0;
    next_blink   = blink;
    if (ms_tick) begin
      next_ms_cnt = (ms_cnt == MS_LAST) ? 10'h000 : ms_cnt + 10'h001;
      next_s_tick = (ms_cnt == MS_LAST);
      if (ms_cnt == HALF_LAST || ms_cnt == MS_LAST) begin
        next_blink = ~blink;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_cnt <= '0;
      ms_cnt  <= 10'h000;
      ms_tick <= 1'b0;
      s_tick  <= 1'b0;
      blink   <= 1'b0;
    end else begin
      pre_cnt <= next_pre_cnt;
      ms_cnt  <= next_ms_cnt;
      ms_tick <= next_ms_tick;
      s_tick  <= next_s_tick;
      blink   <= next_blink;
    end
  end
endmodule // tcs_tick_gen

// >>> verilog/tcs_deglitch.sv
`timescale 1ns/1ps
// Reports a condition that has held without a break for LIMIT ticks
module tcs_deglitch #(
  parameter int LIMIT = 200
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic tick,
  input  wire logic cond,
  output logic      done
);
  localparam int CW = $clog2(LIMIT + 1);
  localparam logic [CW-1:0] LAST = CW'(LIMIT);

  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic          next_done;

  // Any break in the condition restarts the count
  always_comb begin
    next_cnt = cnt;
    if (!cond) begin
      next_cnt = '0;
    end else if (tick && cnt != LAST) begin
      next_cnt = cnt + 1'b1;
    end
    next_done = cond && (cnt == LAST);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt  <= '0;
      done <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      done <= next_done;
    end
  end
endmodule // tcs_deglitch

// >>> verilog/tcs_charge_seq.sv
`timescale 1ns/1ps
// Charge cycle sequencer for a two-cell series pack
module tcs_charge_seq #(
  parameter int MS_PRESCALE = tcs_pkg::MS_TICK_CYCLES,
  parameter int SAFE_H_1    = tcs_pkg::SAFE_H_1,
  parameter int SAFE_H_2    = tcs_pkg::SAFE_H_2,
  parameter int SAFE_H_3    = tcs_pkg::SAFE_H_3
) (
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  input  wire logic        VIN_PRESENT,
  input  wire logic        PACK_ABOVE_PRE,
  input  wire logic        PACK_BELOW_RECHARGE,
  input  wire logic        CV_LOOP_ACTIVE,
  input  wire logic        CURRENT_BELOW_TERM,
  input  wire logic        PACK_OVER_VOLT,
  input  wire logic        CELL_HIGH_OVER,
  input  wire logic        CELL_LOW_OVER,
  input  wire logic        BALANCE_ENABLED,
  input  wire logic        THERM_HOT,
  input  wire logic        THERM_COLD,
  input  wire logic        THERM_TIED_HIGH,
  input  wire logic        THERMAL_SHUTDOWN,
  input  wire logic        VOLTAGE_SETTING_PIN_HIGH,
  input  wire logic [1:0]  VSET_BAND,
  input  wire logic        SYS_BELOW_PACK,
  input  wire logic        BATTERY_ABSENT,
  input  wire logic        CHARGE_ENABLE,
  input  wire logic [1:0]  TIMER_FIELD,
  input  wire logic        SOFT_RESET,
  input  wire logic [1:0]  WATCHDOG_FIELD,
  input  wire logic [3:0]  CHARGE_CURRENT_CODE,
  input  wire logic [13:0] HOST_REG_MV,
  input  wire logic        OTP_INHIBIT,
  input  wire logic        I2C_ACTIVITY,
  output logic             CHARGE_ON,
  output logic             PHASE_PRECHARGE,
  output logic             PHASE_FAST,
  output logic             CHARGE_FULL,
  output logic             PRE_TIMEOUT,
  output logic             SAFETY_TIMEOUT,
  output logic             BATTERY_FET_ON,
  output logic             FET_SUPPLEMENT,
  output logic             BOOST_RUN,
  output logic [13:0]      PACK_REG_MV,
  output logic [3:0]       CURRENT_CODE,
  output logic             STAT_OUT,
  output logic             STAT_OE_N,
  output logic             BATTERY_ABSENT_FLAG,
  output logic             ABSENT_CHECK,
  output logic             WATCHDOG_DEFAULTS,
  output logic             HOST_MODE
);
  localparam int TW = tcs_pkg::TIMER_W;
  localparam int WW = tcs_pkg::WDT_W;

  // Fast-charge limit in seconds for a timer code
  function automatic logic [TW-1:0] safe_limit(input logic [1:0] f);
    case (f)
      2'h1:    safe_limit = TW'(SAFE_H_1 * tcs_pkg::S_PER_H);
      2'h2:    safe_limit = TW'(SAFE_H_2 * tcs_pkg::S_PER_H);
      default: safe_limit = TW'(SAFE_H_3 * tcs_pkg::S_PER_H);
    endcase
  endfunction

  // Watchdog limit in seconds for a watchdog code
  function automatic logic [WW-1:0] wdt_limit(input logic [1:0] f);
    case (f)
      2'h1:    wdt_limit = WW'(tcs_pkg::WDT_S_1);
      2'h2:    wdt_limit = WW'(tcs_pkg::WDT_S_2);
      default: wdt_limit = WW'(tcs_pkg::WDT_S_3);
    endcase
  endfunction

  logic [17:0] pin_raw;
  logic [17:0] sync1;
  logic [17:0] sync2;
  logic        vin, above_pre, below_rech, cv_loop, below_term;
  logic        pack_ovp, cell_hi, cell_lo, bal_en, hot, cold;
  logic        tied_high, tsd, vset_high, sys_low, absent;
  logic [1:0]  band;
  logic        ms_tick, s_tick, blink;
  logic        term_done, hold_done, rech_done;

  // Two-stage synchronisers for all pin-side inputs
  assign pin_raw = {VIN_PRESENT, PACK_ABOVE_PRE, PACK_BELOW_RECHARGE,
                    CV_LOOP_ACTIVE, CURRENT_BELOW_TERM, PACK_OVER_VOLT,
                    CELL_HIGH_OVER, CELL_LOW_OVER, BALANCE_ENABLED,
                    THERM_HOT, THERM_COLD, THERM_TIED_HIGH, THERMAL_SHUTDOWN,
                    VOLTAGE_SETTING_PIN_HIGH, SYS_BELOW_PACK, BATTERY_ABSENT,
                    VSET_BAND};
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      sync1 <= 18'h00000;
      sync2 <= 18'h00000;
    end else begin
      sync1 <= pin_raw;
      sync2 <= sync1;
    end
  end
  assign {vin, above_pre, below_rech, cv_loop, below_term, pack_ovp,
          cell_hi, cell_lo, bal_en, hot, cold, tied_high, tsd,
          vset_high, sys_low, absent, band} = sync2;

  tcs_tick_gen #(.PRESCALE(MS_PRESCALE)) u_tick (
    .clk     (CORE_CLK),
    .rst     (RST),
    .ms_tick (ms_tick),
    .s_tick  (s_tick),
    .blink   (blink)
  );

  tcs_pkg::tcs_state_type state, next_state;
  logic          mode_host, next_mode_host;
  logic          inhibit, next_inhibit;
  logic          cycle_req, next_cycle_req;
  logic          pre_to, next_pre_to;
  logic          safe_to, next_safe_to;
  logic [TW-1:0] tmr, next_tmr;
  logic          vin_q, en_q, srst_q, flt_q;
  logic [1:0]    tmr_q;
  logic          replug, en_rise, tmr_rise, srst_rise, restart;
  logic          ntc_fault, cell_ovp, susp, term_en, in_cycle;
  logic          start_ok, rech_trig, flt_now;

  // Event edges and condition terms
  assign replug    = vin & ~vin_q;
  assign en_rise   = CHARGE_ENABLE & ~en_q;
  assign tmr_rise  = (tmr_q == tcs_pkg::TMR_OFF) & (TIMER_FIELD != tcs_pkg::TMR_OFF);
  assign srst_rise = SOFT_RESET & ~srst_q;
  assign restart   = en_rise | tmr_rise | srst_rise;
  assign ntc_fault = (hot | cold) & ~tied_high;
  assign cell_ovp  = bal_en & (cell_hi | cell_lo);
  assign susp      = ntc_fault | pack_ovp | cell_ovp;
  assign term_en   = ~tied_high;
  assign in_cycle  = (state == tcs_pkg::ST_PRE) | (state == tcs_pkg::ST_FAST) |
                     (state == tcs_pkg::ST_FULL);
  assign start_ok  = cycle_req & CHARGE_ENABLE & vin & ~inhibit & ~ntc_fault &
                     ~pre_to & ~safe_to & ~pack_ovp & ~tsd;
  assign rech_trig = (state == tcs_pkg::ST_FULL) & rech_done;
  assign flt_now   = susp | pre_to | safe_to | tsd;

  // Termination, start hold-off and recharge deglitch
  tcs_deglitch #(.LIMIT(tcs_pkg::TERM_DGL_MS)) u_term (
    .clk  (CORE_CLK),
    .rst  (RST),
    .tick (ms_tick),
    .cond ((state == tcs_pkg::ST_FAST) & cv_loop & below_term & ~susp),
    .done (term_done)
  );
  tcs_deglitch #(.LIMIT(tcs_pkg::HOLDOFF_MS)) u_hold (
    .clk  (CORE_CLK),
    .rst  (RST),
    .tick (ms_tick),
    .cond (in_cycle),
    .done (hold_done)
  );
  tcs_deglitch #(.LIMIT(tcs_pkg::RECHG_DGL_MS)) u_rech (
    .clk  (CORE_CLK),
    .rst  (RST),
    .tick (ms_tick),
    .cond ((state == tcs_pkg::ST_FULL) & below_rech),
    .done (rech_done)
  );

  // Sequence, latched faults and safety timer
  always_comb begin
    next_state     = state;
    next_mode_host = mode_host;
    next_inhibit   = inhibit & ~below_rech;
    next_cycle_req = cycle_req | en_rise;
    next_pre_to    = pre_to;
    next_safe_to   = safe_to;
    next_tmr       = tmr;
    if (s_tick && !ntc_fault && (state == tcs_pkg::ST_PRE ||
        state == tcs_pkg::ST_FAST) && tmr != {TW{1'b1}}) begin
      next_tmr = tmr + 1'b1;
    end
    case (state)
      tcs_pkg::ST_IDLE: begin
        if (start_ok) begin
          next_state     = above_pre ? tcs_pkg::ST_FAST : tcs_pkg::ST_PRE;
          next_cycle_req = 1'b0;
          next_tmr       = '0;
        end
      end
      tcs_pkg::ST_PRE: begin
        if (above_pre) begin
          next_state = tcs_pkg::ST_FAST;
          next_tmr   = '0;
        end else if (tmr >= TW'(tcs_pkg::PRE_TIMER_S)) begin
          next_state  = tcs_pkg::ST_FAULT;
          next_pre_to = 1'b1;
        end
      end
      tcs_pkg::ST_FAST: begin
        if (term_done && hold_done && term_en) begin
          next_state = tcs_pkg::ST_FULL;
        end else if (TIMER_FIELD != tcs_pkg::TMR_OFF &&
                     tmr >= safe_limit(TIMER_FIELD)) begin
          next_state   = tcs_pkg::ST_FAULT;
          next_safe_to = 1'b1;
        end
      end
      tcs_pkg::ST_FULL: begin
        if (rech_trig) begin
          next_state     = tcs_pkg::ST_IDLE;
          next_cycle_req = 1'b1;
        end
      end
      tcs_pkg::ST_FAULT: begin
        next_state = tcs_pkg::ST_FAULT;
      end
      default: begin
        next_state = tcs_pkg::ST_IDLE;
      end
    endcase
    if (restart) begin
      next_tmr     = '0;
      next_pre_to  = next_pre_to & ~pre_to;
      next_safe_to = next_safe_to & ~safe_to; // Fresh timeout beats restart
      if (state == tcs_pkg::ST_FAULT) begin
        next_state     = tcs_pkg::ST_IDLE;
        next_cycle_req = 1'b1;
      end
    end
    if (replug) begin
      next_state     = tcs_pkg::ST_IDLE;
      next_cycle_req = 1'b1;
      next_mode_host = vset_high;
      next_inhibit   = OTP_INHIBIT & ~below_rech;
      next_pre_to    = 1'b0;
      next_safe_to   = 1'b0;
    end
    if (!vin || !CHARGE_ENABLE) begin
      next_state = tcs_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      state     <= tcs_pkg::ST_IDLE;
      mode_host <= 1'b0;
      inhibit   <= 1'b0;
      cycle_req <= 1'b0;
      pre_to    <= 1'b0;
      safe_to   <= 1'b0;
      tmr       <= '0;
      vin_q     <= 1'b0;
      en_q      <= 1'b0;
      srst_q    <= 1'b0;
      flt_q     <= 1'b0;
      tmr_q     <= 2'h0;
    end else begin
      state     <= next_state;
      mode_host <= next_mode_host;
      inhibit   <= next_inhibit;
      cycle_req <= next_cycle_req;
      pre_to    <= next_pre_to;
      safe_to   <= next_safe_to;
      tmr       <= next_tmr;
      vin_q     <= vin;
      en_q      <= CHARGE_ENABLE;
      srst_q    <= SOFT_RESET;
      flt_q     <= flt_now;
      tmr_q     <= TIMER_FIELD;
    end
  end

  logic [WW-1:0] wdt, next_wdt;
  logic          next_wdt_fire;

  // Host-mode bus-idle watchdog
  always_comb begin
    next_wdt      = wdt;
    next_wdt_fire = 1'b0;
    if (!mode_host || WATCHDOG_FIELD == tcs_pkg::WDT_OFF || I2C_ACTIVITY) begin
      next_wdt = '0;
    end else if (s_tick) begin
      if (wdt + 1'b1 >= wdt_limit(WATCHDOG_FIELD)) begin
        next_wdt      = '0;
        next_wdt_fire = 1'b1;
      end else begin
        next_wdt = wdt + 1'b1;
      end
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      wdt               <= '0;
      WATCHDOG_DEFAULTS <= 1'b0;
    end else begin
      wdt               <= next_wdt;
      WATCHDOG_DEFAULTS <= next_wdt_fire;
    end
  end

  logic        run;
  logic        next_stat_oe_n;
  logic [13:0] next_reg_mv;

  // Status pin and regulation target
  assign run = (state == tcs_pkg::ST_PRE || state == tcs_pkg::ST_FAST) & ~susp & ~tsd;
  always_comb begin
    if (susp || pre_to || safe_to || absent) begin
      next_stat_oe_n = blink;
    end else if (run) begin
      next_stat_oe_n = 1'b0;
    end else begin
      next_stat_oe_n = 1'b1;
    end
    if (mode_host) begin
      next_reg_mv = HOST_REG_MV;
    end else begin
      case (band)
        2'h0:    next_reg_mv = tcs_pkg::VREG_BAND0_MV;
        2'h1:    next_reg_mv = tcs_pkg::VREG_BAND1_MV;
        2'h2:    next_reg_mv = tcs_pkg::VREG_BAND2_MV;
        default: next_reg_mv = tcs_pkg::VREG_BAND3_MV;
      endcase
    end
  end

  // Registered outputs
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      CHARGE_ON           <= 1'b0;
      PHASE_PRECHARGE     <= 1'b0;
      PHASE_FAST          <= 1'b0;
      CHARGE_FULL         <= 1'b0;
      PRE_TIMEOUT         <= 1'b0;
      SAFETY_TIMEOUT      <= 1'b0;
      BATTERY_FET_ON      <= 1'b0;
      FET_SUPPLEMENT      <= 1'b0;
      BOOST_RUN           <= 1'b0;
      PACK_REG_MV         <= tcs_pkg::VREG_BAND0_MV;
      CURRENT_CODE        <= tcs_pkg::CURRENT_FULL_SCALE;
      STAT_OUT            <= 1'b0;
      STAT_OE_N           <= 1'b1;
      BATTERY_ABSENT_FLAG <= 1'b0;
      ABSENT_CHECK        <= 1'b0;
      HOST_MODE           <= 1'b0;
    end else begin
      CHARGE_ON           <= run;
      PHASE_PRECHARGE     <= state == tcs_pkg::ST_PRE;
      PHASE_FAST          <= state == tcs_pkg::ST_FAST;
      CHARGE_FULL         <= state == tcs_pkg::ST_FULL;
      PRE_TIMEOUT         <= pre_to;
      SAFETY_TIMEOUT      <= safe_to;
      BATTERY_FET_ON      <= ~pack_ovp & (run | sys_low);
      FET_SUPPLEMENT      <= ~pack_ovp & sys_low;
      BOOST_RUN           <= vin & ~tsd;
      PACK_REG_MV         <= next_reg_mv;
      CURRENT_CODE        <= mode_host ? CHARGE_CURRENT_CODE : tcs_pkg::CURRENT_FULL_SCALE;
      STAT_OUT            <= 1'b0;
      STAT_OE_N           <= next_stat_oe_n;
      BATTERY_ABSENT_FLAG <= mode_host & absent;
      ABSENT_CHECK        <= en_rise | rech_trig | (flt_q & ~flt_now);
      HOST_MODE           <= mode_host;
    end
  end
endmodule // tcs_charge_seq

// >>> bench/tcs_pack_model.sv
`timescale 1ns/1ps
// Two-cell pack: charging raises its level, a drain request lowers it
module tcs_pack_model (
  input  wire logic clk,
  input  wire logic charging,
  input  wire logic drain,
  output logic      above_pre,
  output logic      cv_active,
  output logic      below_term,
  output logic      below_recharge
);
  int level = 0;
  // One step a cycle, changed just after the edge like any other stimulus
  always @(posedge clk) begin
    if (charging && level < 300) begin
      level <= #2 level + 1;
    end else if (drain && level > 0) begin
      level <= #2 level - 1;
    end
  end
  // Pack thresholds seen by the charger
  assign above_pre      = level > 50;
  assign cv_active      = level >= 200;
  assign below_term     = level >= 250;
  assign below_recharge = level < 150;
endmodule // tcs_pack_model

// >>> bench/tcs_seq_chk.sv
`timescale 1ns/1ps
// Relations between the sequencer's pin inputs and its outputs
module tcs_seq_chk #(
  parameter int MS_PRESCALE = 5
) (
  input wire logic        CORE_CLK,
  input wire logic        RST,
  input wire logic        VIN_PRESENT,
  input wire logic        PACK_ABOVE_PRE,
  input wire logic        CV_LOOP_ACTIVE,
  input wire logic        CURRENT_BELOW_TERM,
  input wire logic        PACK_OVER_VOLT,
  input wire logic        CELL_HIGH_OVER,
  input wire logic        CELL_LOW_OVER,
  input wire logic        BALANCE_ENABLED,
  input wire logic        THERM_HOT,
  input wire logic        THERM_COLD,
  input wire logic        THERM_TIED_HIGH,
  input wire logic        THERMAL_SHUTDOWN,
  input wire logic        SYS_BELOW_PACK,
  input wire logic        BATTERY_ABSENT,
  input wire logic [3:0]  CHARGE_CURRENT_CODE,
  input wire logic [13:0] HOST_REG_MV,
  input wire logic        CHARGE_ON,
  input wire logic        PHASE_PRECHARGE,
  input wire logic        CHARGE_FULL,
  input wire logic        BATTERY_FET_ON,
  input wire logic        FET_SUPPLEMENT,
  input wire logic        BOOST_RUN,
  input wire logic [13:0] PACK_REG_MV,
  input wire logic [3:0]  CURRENT_CODE,
  input wire logic        BATTERY_ABSENT_FLAG,
  input wire logic        ABSENT_CHECK,
  input wire logic        HOST_MODE
);
  int run_len;
  int next_run_len;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  // Unbroken cycles of voltage loop with low current
  always_comb begin
    next_run_len = (CV_LOOP_ACTIVE && CURRENT_BELOW_TERM) ? run_len + 1 : 0;
  end
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      run_len <= 0;
    end else begin
      run_len <= next_run_len;
    end
  end
  // Condition held long enough to pass the input synchronisers
  sequence s_held(logic c);
    c [*6];
  endsequence
  ovp_boost_a: assert property (s_held(PACK_OVER_VOLT && VIN_PRESENT && !THERMAL_SHUTDOWN && !SYS_BELOW_PACK)
    |-> BOOST_RUN && !BATTERY_FET_ON && !CHARGE_ON) else $error("pack over-voltage not handled");
  cell_ovp_a: assert property (s_held(BALANCE_ENABLED && (CELL_HIGH_OVER || CELL_LOW_OVER))
    |-> !CHARGE_ON) else $error("cell over-voltage still charging");
  ntc_stop_a: assert property (s_held((THERM_HOT || THERM_COLD) && !THERM_TIED_HIGH)
    |-> !CHARGE_ON) else $error("thermistor fault still charging");
  full_deglitch_a: assert property ($rose(CHARGE_FULL) |-> run_len >= 199 * MS_PRESCALE)
    else $error("charge full before termination deglitch");
  full_tied_a: assert property (s_held(THERM_TIED_HIGH) |-> !$rose(CHARGE_FULL))
    else $error("termination while thermistor tied high");
  pre_exit_a: assert property (s_held(PACK_ABOVE_PRE) |-> !PHASE_PRECHARGE)
    else $error("precharge above threshold");
  supplement_a: assert property (s_held(SYS_BELOW_PACK && !PACK_OVER_VOLT)
    |-> BATTERY_FET_ON && FET_SUPPLEMENT) else $error("supplement mode missing");
  absent_flag_a: assert property (s_held(BATTERY_ABSENT && HOST_MODE) |-> BATTERY_ABSENT_FLAG)
    else $error("absent flag not set");
  host_volt_a: assert property ((HOST_MODE && $stable(HOST_REG_MV)) [*5] |-> PACK_REG_MV == HOST_REG_MV)
    else $error("host voltage not applied");
  host_cur_a: assert property ((HOST_MODE && $stable(CHARGE_CURRENT_CODE)) [*5]
    |-> CURRENT_CODE == CHARGE_CURRENT_CODE) else $error("host current not applied");
  check_pulse_a: assert property (ABSENT_CHECK |=> !ABSENT_CHECK)
    else $error("absent check longer than a cycle");
endmodule // tcs_seq_chk

bind tcs_charge_seq tcs_seq_chk #(.MS_PRESCALE(MS_PRESCALE)) u_chk (.CORE_CLK, .RST, .VIN_PRESENT, .PACK_ABOVE_PRE,
  .CV_LOOP_ACTIVE, .CURRENT_BELOW_TERM, .PACK_OVER_VOLT, .CELL_HIGH_OVER, .CELL_LOW_OVER, .BALANCE_ENABLED,
  .THERM_HOT, .THERM_COLD, .THERM_TIED_HIGH, .THERMAL_SHUTDOWN, .SYS_BELOW_PACK, .BATTERY_ABSENT,
  .CHARGE_CURRENT_CODE, .HOST_REG_MV, .CHARGE_ON, .PHASE_PRECHARGE, .CHARGE_FULL, .BATTERY_FET_ON,
  .FET_SUPPLEMENT, .BOOST_RUN, .PACK_REG_MV, .CURRENT_CODE, .BATTERY_ABSENT_FLAG, .ABSENT_CHECK, .HOST_MODE);

// >>> bench/tcs_charge_seq_bench.sv
`timescale 1ns/1ps
// Self-checking bench: pack model on the battery side, register bits driven directly
module tcs_charge_seq_bench;
  localparam int P = 5;
  int seed = 48;
  int miscompares = 0;
  int n_compared = 0;
  int n;
  int band_mv[4] = '{8400, 8600, 8700, 8800};
  logic [17:0] exp_q[$];
  logic CORE_CLK = 1'h0, RST = 1'h1, VIN_PRESENT = 1'h0, PACK_OVER_VOLT = 1'h0, CELL_HIGH_OVER = 1'h0;
  logic CELL_LOW_OVER = 1'h0, BALANCE_ENABLED = 1'h0, THERM_HOT = 1'h0, THERM_COLD = 1'h0, THERM_TIED_HIGH = 1'h0;
  logic THERMAL_SHUTDOWN = 1'h0, VOLTAGE_SETTING_PIN_HIGH = 1'h0, SYS_BELOW_PACK = 1'h0, BATTERY_ABSENT = 1'h0;
  logic CHARGE_ENABLE = 1'h0, SOFT_RESET = 1'h0, OTP_INHIBIT = 1'h0, I2C_ACTIVITY = 1'h0, drain = 1'h0;
  logic [1:0] VSET_BAND = 2'h0, TIMER_FIELD = 2'h1, WATCHDOG_FIELD = 2'h0;
  logic [3:0] CHARGE_CURRENT_CODE = 4'h0;
  logic [13:0] HOST_REG_MV = 14'h0;
  logic PACK_ABOVE_PRE, PACK_BELOW_RECHARGE, CV_LOOP_ACTIVE, CURRENT_BELOW_TERM, CHARGE_ON, PHASE_PRECHARGE;
  logic PHASE_FAST, CHARGE_FULL, PRE_TIMEOUT, SAFETY_TIMEOUT, BATTERY_FET_ON, FET_SUPPLEMENT, BOOST_RUN;
  logic STAT_OUT, STAT_OE_N, BATTERY_ABSENT_FLAG, ABSENT_CHECK, WATCHDOG_DEFAULTS, HOST_MODE;
  logic [13:0] PACK_REG_MV;
  logic [3:0] CURRENT_CODE;
  // Clock of 20 ns
  always #10 CORE_CLK = ~CORE_CLK;
  tcs_charge_seq #(.MS_PRESCALE(P)) dut (.CORE_CLK, .RST, .VIN_PRESENT, .PACK_ABOVE_PRE, .PACK_BELOW_RECHARGE,
    .CV_LOOP_ACTIVE, .CURRENT_BELOW_TERM, .PACK_OVER_VOLT, .CELL_HIGH_OVER, .CELL_LOW_OVER, .BALANCE_ENABLED,
    .THERM_HOT, .THERM_COLD, .THERM_TIED_HIGH, .THERMAL_SHUTDOWN, .VOLTAGE_SETTING_PIN_HIGH, .VSET_BAND,
    .SYS_BELOW_PACK, .BATTERY_ABSENT, .CHARGE_ENABLE, .TIMER_FIELD, .SOFT_RESET, .WATCHDOG_FIELD,
    .CHARGE_CURRENT_CODE, .HOST_REG_MV, .OTP_INHIBIT, .I2C_ACTIVITY, .CHARGE_ON, .PHASE_PRECHARGE, .PHASE_FAST,
    .CHARGE_FULL, .PRE_TIMEOUT, .SAFETY_TIMEOUT, .BATTERY_FET_ON, .FET_SUPPLEMENT, .BOOST_RUN, .PACK_REG_MV,
    .CURRENT_CODE, .STAT_OUT, .STAT_OE_N, .BATTERY_ABSENT_FLAG, .ABSENT_CHECK, .WATCHDOG_DEFAULTS, .HOST_MODE);
  tcs_pack_model pack (.clk(CORE_CLK), .charging(CHARGE_ON), .drain(drain), .above_pre(PACK_ABOVE_PRE),
    .cv_active(CV_LOOP_ACTIVE), .below_term(CURRENT_BELOW_TERM), .below_recharge(PACK_BELOW_RECHARGE));
  // Verdict and end of run
  task automatic results;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Move to just after the n-th next rising edge
  task automatic step(int n);
    repeat (n) @(posedge CORE_CLK);
    #2;
  endtask
  task automatic chk(string nm, logic [13:0] e, logic [13:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic sig(int k);
    case (k)
      0: return CHARGE_ON;
      1: return PHASE_PRECHARGE;
      2: return PHASE_FAST;
      3: return CHARGE_FULL;
      4: return ABSENT_CHECK;
      default: return STAT_OE_N;
    endcase
  endfunction
  // Bounded wait for an output level; cycles spent come back in n
  task automatic wt(int k, logic v, int lim, output int n);
    n = 0;
    while (sig(k) !== v && n < lim) begin
      step(1);
      n++;
    end
    if (n >= lim) begin
      miscompares++;
      $display("[ERR] output %0d expected %b seen timeout", k, v);
      results();
    end
  endtask
  task automatic setf(int f, logic v);
    case (f)
      0: PACK_OVER_VOLT = v;
      1: CELL_HIGH_OVER = v;
      2: CELL_LOW_OVER = v;
      3: THERM_HOT = v;
      default: THERM_COLD = v;
    endcase
    BALANCE_ENABLED = v;
  endtask
  task automatic replug;
    VIN_PRESENT = 1'h0;
    step(6);
    VIN_PRESENT = 1'h1;
  endtask
  // Main sequence
  initial begin
    step(3);
    RST = 1'h0;
    step(1);
    chk("reg_mv", 14'h20d0, PACK_REG_MV);
    chk("cur", 14'hf, 14'(CURRENT_CODE));
    $display("reset test done");
    for (int b = 0; b < 4; b++) begin
      VSET_BAND = 2'(b);
      replug();
      step(8);
      chk("band_mv", 14'(band_mv[b]), PACK_REG_MV);
    end
    $display("band test done");
    CHARGE_ENABLE = 1'h1;
    wt(4, 1'h1, 20, n);
    wt(1, 1'h1, 20, n);
    wt(2, 1'h1, 200, n);
    chk("pre", 14'h0, 14'(PHASE_PRECHARGE));
    wt(3, 1'h1, 1500, n);
    chk("charge_on", 14'h0, 14'(CHARGE_ON));
    replug();
    wt(2, 1'h1, 20, n);
    wt(3, 1'h1, 1300, n);
    chk("holdoff", 14'h1, 14'(n >= 990));
    $display("cycle test done");
    drain = 1'h1;
    wt(4, 1'h1, 1400, n);
    chk("recharge", 14'h1, 14'(n >= 1140));
    drain = 1'h0;
    wt(0, 1'h1, 20, n);
    $display("recharge test done");
    for (int f = 0; f < 5; f++) begin
      setf(f, 1'h1);
      step(10);
      chk("charge_on", 14'h0, 14'(CHARGE_ON));
      if (f == 0) begin
        chk("fet_boost", 14'h1, {12'h0, BATTERY_FET_ON, BOOST_RUN});
      end
      setf(f, 1'h0);
      wt(0, 1'h1, 20, n);
    end
    THERM_TIED_HIGH = 1'h1;
    step(1600);
    chk("full", 14'h0, 14'(CHARGE_FULL));
    THERM_TIED_HIGH = 1'h0;
    wt(3, 1'h1, 1300, n);
    THERMAL_SHUTDOWN = 1'h1;
    step(8);
    chk("boost", 14'h0, 14'(BOOST_RUN));
    THERMAL_SHUTDOWN = 1'h0;
    SYS_BELOW_PACK = 1'h1;
    step(8);
    chk("supplement", 14'h3, {12'h0, BATTERY_FET_ON, FET_SUPPLEMENT});
    SYS_BELOW_PACK = 1'h0;
    $display("protection test done");
    OTP_INHIBIT = 1'h1;
    replug();
    step(30);
    chk("charge_on", 14'h0, 14'(CHARGE_ON));
    drain = 1'h1;
    wt(0, 1'h1, 1400, n);
    drain = 1'h0;
    OTP_INHIBIT = 1'h0;
    $display("inhibit test done");
    VOLTAGE_SETTING_PIN_HIGH = 1'h1;
    WATCHDOG_FIELD = 2'h1;
    SOFT_RESET = 1'h1;
    replug();
    step(8);
    chk("host", 14'h1, 14'(HOST_MODE));
    for (int i = 0; i < 8; i++) begin
      HOST_REG_MV = 14'(8000 + ($random(seed) & 1023));
      CHARGE_CURRENT_CODE = 4'($random(seed));
      I2C_ACTIVITY = ~I2C_ACTIVITY;
      exp_q.push_back({CHARGE_CURRENT_CODE, HOST_REG_MV});
      step(8);
      chk("reg_mv", exp_q[0][13:0], PACK_REG_MV);
      chk("cur", 14'(exp_q.pop_front() >> 14), 14'(CURRENT_CODE));
    end
    BATTERY_ABSENT = 1'h1;
    step(8);
    chk("flag", 14'h1, 14'(BATTERY_ABSENT_FLAG));
    wt(5, ~STAT_OE_N, 2600, n);
    wt(5, ~STAT_OE_N, 2600, n);
    chk("blink", 14'h1, 14'(n >= 2490 && n <= 2510));
    chk("flags", 14'h0, {10'h0, STAT_OUT, WATCHDOG_DEFAULTS, PRE_TIMEOUT, SAFETY_TIMEOUT});
    $display("host test done");
    results();
  end
endmodule // tcs_charge_seq_bench
